/* File: rtl/fca_pkg.sv */
// package: register map, field layout and types for the fifo chain config block
package fca_pkg;
	// =====================================================
	// register byte offsets
	localparam logic [11:0] FCA_OFS_BLK_SEL = 12'h910; // rx block link select
	localparam logic [11:0] FCA_OFS_BLK_DATA = 12'h914; // rx next block link data
	localparam logic [11:0] FCA_OFS_WM_SEL = 12'h920; // rx watermark channel select
	localparam logic [11:0] FCA_OFS_WM_DATA = 12'h924; // rx watermark data
	localparam logic [11:0] FCA_OFS_TX_SEL = 12'h980; // tx start pointer channel select
	localparam logic [11:0] FCA_OFS_CHAN_CTL = 12'h930; // per-channel fill/eof control
	localparam logic [11:0] FCA_OFS_CHAN_STAT = 12'h934; // dma request status
	// =====================================================
	// field positions
	localparam int FCA_DIR_BIT = 14; // indirect_direction
	localparam int FCA_BUSY_BIT = 15; // indirect_busy_flag
	localparam int FCA_IDX_W = 9; // block_index / pointer width
	localparam int FCA_CH_W = 6; // channel_index width
	localparam int FCA_NUM_BLK = 512; // blocks in the fifo
	localparam int FCA_NUM_CH = 40; // channels
	// =====================================================
	// reset values
	localparam logic [15:0] FCA_SEL_RST = 16'h0000; // select registers
	localparam logic [8:0] FCA_DATA_RST = 9'h000; // data registers
	// cycles a fetch keeps busy high (access and done states); a store keeps it high one cycle
	localparam logic [1:0] FCA_ACC_CYC = 2'h2;
	// =====================================================
	// indirect engine states
	typedef enum logic [1:0]
	{
		FCA_IDLE = 2'b00,
		FCA_BLK_ACC = 2'b01,
		FCA_WM_ACC = 2'b10,
		FCA_DONE = 2'b11
	} fca_state_t;
	// one pending indirect request
	typedef struct packed
	{
		logic dir; // 1 = fetch, 0 = store
		logic [8:0] idx; // block or channel index
	} fca_req_t;
endpackage

/* File: rtl/fca_top.sv */
// fifo chain config: indirect access to block link ram and rx watermark ram
`timescale 1ns/1ps
module fca_top
	import fca_pkg::*;
#(
	parameter int NUM_CH = FCA_NUM_CH
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [NUM_CH-1:0] dma_req // drain request per channel
);
	// =====================================================
	// storage
	logic [8:0] link_ram [0:FCA_NUM_BLK-1]; // next-block pointers
	logic [8:0] wm_ram [0:63]; // watermarks, 40 used
	logic [15:0] blk_sel_q; // block select, busy bit unused here
	logic [8:0] blk_data_q; // next block data register
	logic [15:0] wm_sel_q; // watermark select
	logic [8:0] wm_data_q; // watermark data register
	logic [15:0] tx_sel_q; // tx start pointer select
	logic [8:0] fill_cnt_q [0:63]; // blocks filled per channel
	logic [63:0] drain_q; // dma draining flags
	fca_state_t state_q;
	fca_req_t req_q;
	logic [1:0] acc_cnt_q;
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	logic [NUM_CH-1:0] dma_req_q;
	// channel-side event register (software stand-in for hdlc/dma strobes)
	logic [15:0] chan_ctl_q;

	// =====================================================
	// bus decode
	logic setup;
	logic wr_en;
	logic busy;
	assign setup = psel && !penable;
	assign wr_en = psel && penable && pwrite && pready_q;
	assign busy = (state_q != FCA_IDLE);

	// address in map
	function automatic logic hit(input logic [11:0] a);
		hit = (a == FCA_OFS_BLK_SEL) || (a == FCA_OFS_BLK_DATA) || (a == FCA_OFS_WM_SEL) ||
			(a == FCA_OFS_WM_DATA) || (a == FCA_OFS_TX_SEL) || (a == FCA_OFS_CHAN_CTL) ||
			(a == FCA_OFS_CHAN_STAT);
	endfunction

	// zero-wait-state answer: pready in the first access cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end
		else
		begin
			pready_q <= setup;
			pslverr_q <= setup && !hit(paddr);
		end
	end

	// read mux, captured in setup so it is ready in access
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata_q <= 32'h0;
		else if (setup && !pwrite)
		begin
			case (paddr)
				// busy bit mirrored read-only
				FCA_OFS_BLK_SEL: prdata_q <= {16'h0, busy, blk_sel_q[14:0]};
				FCA_OFS_BLK_DATA: prdata_q <= {23'h0, blk_data_q};
				FCA_OFS_WM_SEL: prdata_q <= {16'h0, busy, wm_sel_q[14:0]};
				FCA_OFS_WM_DATA: prdata_q <= {23'h0, wm_data_q};
				FCA_OFS_TX_SEL: prdata_q <= {16'h0, 1'b0, tx_sel_q[14:0]};
				FCA_OFS_CHAN_CTL: prdata_q <= {16'h0, chan_ctl_q};
				FCA_OFS_CHAN_STAT: prdata_q <= 32'(drain_q[31:0]);
				default: prdata_q <= 32'h0;
			endcase
		end
	end

	// =====================================================
	// select and channel control registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			blk_sel_q <= FCA_SEL_RST;
			wm_sel_q <= FCA_SEL_RST;
			tx_sel_q <= FCA_SEL_RST; // all fields zero
			chan_ctl_q <= FCA_SEL_RST;
		end
		else if (wr_en)
		begin
			case (paddr)
				// block index bits 0..8, dir bit 14
				FCA_OFS_BLK_SEL: if (!busy) blk_sel_q <= {1'b0, pwdata[14], 5'h0, pwdata[8:0]};
				// channel code bits 0..5
				FCA_OFS_WM_SEL: if (!busy) wm_sel_q <= {1'b0, pwdata[14], 8'h0, pwdata[5:0]};
				FCA_OFS_TX_SEL: tx_sel_q <= {1'b0, pwdata[14], 8'h0, pwdata[5:0]};
				FCA_OFS_CHAN_CTL: chan_ctl_q <= {pwdata[15:14], 8'h0, pwdata[5:0]};
				default: ;
			endcase
		end
		else
			chan_ctl_q[15:14] <= 2'b00; // event strobes self-clear
	end

	// data registers: host writes, or fetch result
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			blk_data_q <= FCA_DATA_RST;
			wm_data_q <= FCA_DATA_RST;
		end
		else if (state_q == FCA_DONE && req_q.dir)
		begin
			if (acc_cnt_q == 2'h1)
				blk_data_q <= link_ram[req_q.idx]; // fetched link
			else
				wm_data_q <= wm_ram[req_q.idx[5:0]]; // fetched watermark
		end
		else if (wr_en && !busy && paddr == FCA_OFS_BLK_DATA)
			blk_data_q <= pwdata[8:0];
		else if (wr_en && !busy && paddr == FCA_OFS_WM_DATA)
			wm_data_q <= pwdata[8:0];
	end

	// =====================================================
	// indirect engine
	logic start_blk;
	logic start_wm;
	assign start_blk = wr_en && !busy && paddr == FCA_OFS_BLK_SEL;
	assign start_wm = wr_en && !busy && paddr == FCA_OFS_WM_SEL;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_q <= FCA_IDLE;
			req_q <= '0;
			acc_cnt_q <= 2'h0;
		end
		else
		begin
			case (state_q)
				FCA_IDLE:
				begin
					if (start_blk)
					begin
						state_q <= FCA_BLK_ACC; // busy rises
						req_q <= '{dir: pwdata[FCA_DIR_BIT], idx: pwdata[8:0]};
					end
					else if (start_wm)
					begin
						state_q <= FCA_WM_ACC; // busy rises
						req_q <= '{dir: pwdata[FCA_DIR_BIT], idx: {3'h0, pwdata[5:0]}};
					end
					acc_cnt_q <= FCA_ACC_CYC;
				end
				FCA_BLK_ACC:
				begin
					if (!req_q.dir)
						state_q <= FCA_IDLE; // store done, busy drops
					else
						state_q <= FCA_DONE;
					acc_cnt_q <= 2'h1; // marks link target
				end
				FCA_WM_ACC:
				begin
					if (!req_q.dir)
						state_q <= FCA_IDLE; // store done
					else
						state_q <= FCA_DONE;
					acc_cnt_q <= 2'h2; // marks watermark target
				end
				FCA_DONE: state_q <= FCA_IDLE; // data now readable
				default: state_q <= FCA_IDLE;
			endcase
		end
	end

	// ram stores, no reset on memories
	always_ff @(posedge pclk)
	begin
		if (state_q == FCA_BLK_ACC && !req_q.dir)
			link_ram[req_q.idx] <= blk_data_q;
		if (state_q == FCA_WM_ACC && !req_q.dir)
			wm_ram[req_q.idx[5:0]] <= wm_data_q;
	end

	// =====================================================
	// rx drain: fill counts against watermark
	// chan_ctl bit 15 = block filled, bit 14 = eof, bits 5:0 = channel
	logic [5:0] ev_ch;
	assign ev_ch = chan_ctl_q[5:0];

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			drain_q <= 64'h0;
			for (int i = 0; i < 64; i++)
				fill_cnt_q[i] <= FCA_DATA_RST;
		end
		else if (chan_ctl_q[15] || chan_ctl_q[14])
		begin
			if (drain_q[ev_ch])
				fill_cnt_q[ev_ch] <= FCA_DATA_RST; // drain running, block absorbed, this channel's count stays zero
			else if (chan_ctl_q[14])
			begin
				drain_q[ev_ch] <= 1'b1; // eof before watermark
				fill_cnt_q[ev_ch] <= FCA_DATA_RST;
			end
			else if (fill_cnt_q[ev_ch] + 9'h1 >= wm_ram[ev_ch] && wm_ram[ev_ch] != 9'h0)
			begin
				drain_q[ev_ch] <= 1'b1; // watermark reached
				fill_cnt_q[ev_ch] <= FCA_DATA_RST;
			end
			else
				fill_cnt_q[ev_ch] <= fill_cnt_q[ev_ch] + 9'h1;
		end
		// an event in the same cycle takes the branch above, so the clear write is dropped
		else if (wr_en && paddr == FCA_OFS_CHAN_STAT)
			drain_q <= drain_q & ~{32'h0, pwdata}; // dma done, write 1 to clear, bits 31:0 only; flags 32 and up are never cleared
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			dma_req_q <= '0;
		else
			dma_req_q <= drain_q[NUM_CH-1:0];
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign dma_req = dma_req_q;

	// =====================================================
	// assertions
	property p_busy_fetch;
		@(posedge pclk) disable iff (!presetn)
		start_blk && pwdata[FCA_DIR_BIT] |=> busy ##1 busy ##1 !busy;
	endproperty
	a_busy_fetch: assert property (p_busy_fetch) else $error("fetch busy timing wrong");
	property p_busy_store;
		@(posedge pclk) disable iff (!presetn)
		start_blk && !pwdata[FCA_DIR_BIT] |=> busy ##1 !busy;
	endproperty
	a_busy_store: assert property (p_busy_store) else $error("store busy timing wrong");
	property p_fetch_data;
		@(posedge pclk) disable iff (!presetn)
		state_q == FCA_DONE && req_q.dir && acc_cnt_q == 2'h1 |=> blk_data_q == link_ram[$past(req_q.idx)];
	endproperty
	a_fetch_data: assert property (p_fetch_data) else $error("link fetch data wrong");
	property p_wm_fetch;
		@(posedge pclk) disable iff (!presetn)
		start_wm && pwdata[FCA_DIR_BIT] |=> busy ##1 busy ##1 !busy;
	endproperty
	a_wm_fetch: assert property (p_wm_fetch) else $error("watermark fetch timing wrong");
	property p_wm_store;
		@(posedge pclk) disable iff (!presetn)
		start_wm && !pwdata[FCA_DIR_BIT] |=> busy ##1 !busy;
	endproperty
	a_wm_store: assert property (p_wm_store) else $error("watermark store timing wrong");
	property p_idx_width;
		@(posedge pclk) disable iff (!presetn)
		start_blk |=> req_q.idx == $past(pwdata[8:0]);
	endproperty
	a_idx_width: assert property (p_idx_width) else $error("block index not captured");
	property p_ch_width;
		@(posedge pclk) disable iff (!presetn)
		start_wm |=> req_q.idx == {3'h0, $past(pwdata[5:0])};
	endproperty
	a_ch_width: assert property (p_ch_width) else $error("channel index not captured");
	property p_tx_busy_zero;
		@(posedge pclk) disable iff (!presetn)
		setup && !pwrite && paddr == FCA_OFS_TX_SEL |=> prdata[15] == 1'b0 && prdata[13:6] == 8'h0;
	endproperty
	a_tx_busy_zero: assert property (p_tx_busy_zero) else $error("tx select read shows busy or reserved bits");
	property p_eof_drain;
		@(posedge pclk) disable iff (!presetn)
		chan_ctl_q[14] && !chan_ctl_q[15] |=> drain_q[$past(ev_ch)];
	endproperty
	a_eof_drain: assert property (p_eof_drain) else $error("eof did not request drain");
	property p_ready_wait;
		@(posedge pclk) disable iff (!presetn)
		setup |=> pready;
	endproperty
	a_ready_wait: assert property (p_ready_wait) else $error("pready late");
	// a store lands in the link ram at the end of its access cycle
	property p_link_store;
		@(posedge pclk) disable iff (!presetn)
		state_q == FCA_BLK_ACC && !req_q.dir |=> link_ram[$past(req_q.idx)] == $past(blk_data_q);
	endproperty
	a_link_store: assert property (p_link_store) else $error("link store did not land");
	// blocks arriving while a drain runs are absorbed, drain stays on
	property p_drain_absorb;
		@(posedge pclk) disable iff (!presetn)
		chan_ctl_q[15] && drain_q[ev_ch] |=> drain_q[$past(ev_ch)] && fill_cnt_q[$past(ev_ch)] == FCA_DATA_RST;
	endproperty
	a_drain_absorb: assert property (p_drain_absorb) else $error("block during drain not absorbed");
	// a zero watermark is invalid and never starts a drain on a filled block; eof still does
	property p_wm_zero;
		@(posedge pclk) disable iff (!presetn)
		chan_ctl_q[15] && !chan_ctl_q[14] && !drain_q[ev_ch] && wm_ram[ev_ch] == 9'h0 |=> !drain_q[$past(ev_ch)];
	endproperty
	a_wm_zero: assert property (p_wm_zero) else $error("zero watermark started a drain");
	c_fetch: cover property (@(posedge pclk) start_blk && pwdata[FCA_DIR_BIT]);
	c_wm_store: cover property (@(posedge pclk) start_wm && !pwdata[FCA_DIR_BIT]);
	c_drain: cover property (@(posedge pclk) $rose(dma_req[2]));
	c_eof: cover property (@(posedge pclk) chan_ctl_q[14]);
endmodule

/* File: tb/fca_top_tb_top.sv */
// testbench: apb-driven checks of the fifo chain config block
`timescale 1ns/1ps
module fca_top_tb_top;
	import fca_pkg::*;
	// =====================================================
	// clock, reset, bus and observed signals
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [FCA_NUM_CH-1:0] dma_req;
	int errors = 0; // mismatches
	int samples_checked = 0; // comparisons made
	int cycles = 0; // hang guard
	logic [31:0] rd; // last read data
	logic err; // last slave error
	fca_top #(.NUM_CH(FCA_NUM_CH)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .dma_req(dma_req));
	// free-running 200 mhz clock
	initial
	begin
		forever #2.5 pclk = ~pclk;
	end
	// =====================================================
	// verdict and hang guard
	task automatic summarize();
		$display("checks %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// a stuck handshake ends the run as a failure
	always @(posedge pclk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			errors++;
			summarize();
		end
	end
	// =====================================================
	// compare and bus tasks
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			errors++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// one apb transfer: setup, then access until pready
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rdx(input string name, input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(name, rd, exp);
	endtask
	// poll the select register until busy drops, bounded
	task automatic idle(input logic [11:0] sel);
		int n;
		n = 0;
		do
		begin
			apb(1'b0, sel, 32'h0);
			n++;
		end
		while (rd[FCA_BUSY_BIT] !== 1'b0 && n < 20);
		check("busy_clears", {31'h0, rd[FCA_BUSY_BIT]}, 32'h0);
	endtask
	// preload data, then indirect store
	task automatic store(input logic [11:0] sel, input logic [11:0] dat, input logic [8:0] idx, input logic [8:0] v);
		wr(dat, {23'h0, v});
		wr(sel, {23'h0, idx});
		idle(sel);
	endtask
	// clobber data, indirect fetch, expect busy then the stored value
	task automatic fetch(input logic [11:0] sel, input logic [11:0] dat, input logic [8:0] idx, input logic [8:0] v);
		wr(dat, {23'h0, ~v});
		wr(sel, 32'h00004000 | {23'h0, idx});
		rdx("busy_during_fetch", sel, 32'h0000c000 | {23'h0, idx});
		idle(sel);
		rdx("fetched_data", dat, {23'h0, v});
	endtask
	// =====================================================
	// main sequence
	logic [8:0] bidx [3] = '{9'h000, 9'h1ff, 9'h0aa}; // block indices
	logic [8:0] bval [3] = '{9'h1ff, 9'h000, 9'h155}; // next-block links
	logic [8:0] cidx [3] = '{9'h000, 9'h027, 9'h013}; // channel codes
	logic [8:0] cval [3] = '{9'h1ff, 9'h001, 9'h0aa}; // watermarks
	initial
	begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		// reset values of the select registers
		rdx("blk_sel_rst", FCA_OFS_BLK_SEL, 32'h0);
		rdx("wm_sel_rst", FCA_OFS_WM_SEL, 32'h0);
		rdx("tx_sel_rst", FCA_OFS_TX_SEL, 32'h0);
		// unmapped address is refused
		apb(1'b0, 12'h9f0, 32'h0);
		check("unmapped_err", {31'h0, err}, 32'h1);
		check("unmapped_rd", rd, 32'h0);
		// tx select keeps only its fields, busy reads 0
		wr(FCA_OFS_TX_SEL, 32'h0000ffff);
		rdx("tx_sel_fields", FCA_OFS_TX_SEL, 32'h0000403f);
		check("mapped_err", {31'h0, err}, 32'h0);
		// link ram: store all, then fetch back, boundary indices
		for (int i = 0; i < 3; i++)
			store(FCA_OFS_BLK_SEL, FCA_OFS_BLK_DATA, bidx[i], bval[i]);
		for (int i = 0; i < 3; i++)
			fetch(FCA_OFS_BLK_SEL, FCA_OFS_BLK_DATA, bidx[i], bval[i]);
		// watermark ram over first, last and middle channel codes
		for (int i = 0; i < 3; i++)
			store(FCA_OFS_WM_SEL, FCA_OFS_WM_DATA, cidx[i], cval[i]);
		for (int i = 0; i < 3; i++)
			fetch(FCA_OFS_WM_SEL, FCA_OFS_WM_DATA, cidx[i], cval[i]);
		// watermark 3 on code 2: two blocks do not drain, the third does
		store(FCA_OFS_WM_SEL, FCA_OFS_WM_DATA, 9'h002, 9'h003); // three-block chain
		repeat (2) wr(FCA_OFS_CHAN_CTL, 32'h00008002);
		rdx("stat_below_wm", FCA_OFS_CHAN_STAT, 32'h0);
		check("dma_below_wm", dma_req[31:0], 32'h0);
		wr(FCA_OFS_CHAN_CTL, 32'h00008002);
		rdx("stat_at_wm", FCA_OFS_CHAN_STAT, 32'h4);
		check("dma_at_wm", dma_req[31:0], 32'h4);
		wr(FCA_OFS_CHAN_STAT, 32'h4);
		rdx("stat_cleared", FCA_OFS_CHAN_STAT, 32'h0);
		check("dma_cleared", dma_req[31:0], 32'h0);
		// end of frame before watermark still requests a drain
		store(FCA_OFS_WM_SEL, FCA_OFS_WM_DATA, 9'h005, 9'h004); // four-block chain
		wr(FCA_OFS_CHAN_CTL, 32'h00008005);
		rdx("stat_pre_eof", FCA_OFS_CHAN_STAT, 32'h0);
		wr(FCA_OFS_CHAN_CTL, 32'h00004005);
		rdx("stat_eof", FCA_OFS_CHAN_STAT, 32'h20);
		// last channel code 27h, watermark 1: one block drains
		wr(FCA_OFS_CHAN_CTL, 32'h00008027);
		rdx("stat_ch40", FCA_OFS_CHAN_STAT, 32'h20);
		check("dma_ch40", {31'h0, dma_req[39]}, 32'h1);
		// a further block while draining is absorbed, request stays
		wr(FCA_OFS_CHAN_CTL, 32'h00008027);
		rdx("stat_absorb", FCA_OFS_CHAN_STAT, 32'h20);
		check("dma_ch40_held", {31'h0, dma_req[39]}, 32'h1);
		// zero watermark is invalid and filled blocks never drain it
		store(FCA_OFS_WM_SEL, FCA_OFS_WM_DATA, 9'h003, 9'h000);
		repeat (2) wr(FCA_OFS_CHAN_CTL, 32'h00008003);
		rdx("stat_wm_zero", FCA_OFS_CHAN_STAT, 32'h20);
		// event strobes self-clear, channel code stays readable
		rdx("chan_ctl_rd", FCA_OFS_CHAN_CTL, 32'h3);
		summarize();
	end
endmodule
